// File: rtl/lbrs_sequencer.sv
// LCD bias rail sequencer: power-up order, fault latch-off, gate shaping
`timescale 1ns/10ps
`include "lbrs_defines.svh"

// Restartable interval timer with done flag and linear ramp level
module lbrs_interval_timer (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Timing
  input wire logic tick,
  input wire logic run,
  input wire logic [`LBRS_TIME_W-1:0] limit,
  // Results
  output logic done,
  output logic [7:0] level
);
  logic [`LBRS_TIME_W-1:0] count; // Ticks since run rose
  logic [`LBRS_TIME_W-1:0] sub; // Ticks within one ramp step
  logic [`LBRS_TIME_W-1:0] next_count;
  logic [`LBRS_TIME_W-1:0] next_sub;
  logic next_done;
  logic [7:0] next_level;

  // Count while run holds, restart when it drops
  always_comb begin
    next_count = count;
    next_sub = sub;
    next_done = done;
    next_level = level;
    if (!run) begin // Restart on each new qualifying period [RULE24]
      next_count = '0;
      next_sub = '0;
      next_done = 1'b0;
      next_level = 8'h00;
    end else if (count >= limit) begin // Interval over
      next_done = 1'b1;
      next_level = 8'hFF;
    end else if (tick) begin
      next_count = count + `LBRS_TIME_W'(1);
      if (sub >= (limit >> 8)) begin // One ramp step every (limit >> 8) + 1 ticks
        next_sub = '0;
        if (level != 8'hFF) begin
          next_level = level + 8'h01;
        end
      end else begin
        next_sub = sub + `LBRS_TIME_W'(1);
      end
    end
  end

  // Register timer state
  always_ff @(posedge mclk) begin
    if (srst) begin
      count <= '0;
      sub <= '0;
      done <= 1'b0;
      level <= 8'h00;
    end else begin
      count <= next_count;
      sub <= next_sub;
      done <= next_done;
      level <= next_level;
    end
  end
endmodule : lbrs_interval_timer

// Top of the sequencer
module lbrs_sequencer #(
  parameter int TICK_CYCLES = `LBRS_TICK_CYCLES,
  parameter int UV_FILTER_TICKS = `LBRS_UV_FILTER_TICKS
) (
  // Clock and power-on reset
  input wire logic mclk,
  input wire logic srst,
  // Settings and analog comparisons
  input lbrs_pkg::lbrs_cfg_t cfg,
  input wire logic supply_above_lockout,
  input wire logic [3:0] rail_below_70,
  input wire logic [3:0] rail_below_30,
  input wire logic shaping_control_input,
  // Open-drain system reset pin
  input wire logic system_reset_i,
  output logic system_reset_o,
  output logic system_reset_oe_n,
  // Rail and switch drive
  output lbrs_pkg::lbrs_rail_t rail,
  output lbrs_pkg::lbrs_shape_t shape,
  // Status
  output logic [3:0] ramp_done,
  output logic fault_latched
);
  import lbrs_pkg::*;

  lbrs_state_t state; // Sequencer state
  lbrs_state_t next_state;
  logic [15:0] tb_count; // Shared timebase divider
  logic [15:0] next_tb_count;
  logic tick; // One-cycle timebase tick
  logic next_tick;
  logic [16:0] uv_count [`LBRS_NUM_RAILS]; // Undervoltage filters
  logic [16:0] next_uv_count [`LBRS_NUM_RAILS];
  logic logic_rail_up; // Logic rail has finished rising
  logic next_logic_rail_up;
  logic reset_released; // Reset output latched high
  logic next_reset_released;
  logic shape_prev; // Previous shaping control level
  logic shape_discharging; // Falling edge seen, still low
  logic next_shape_discharging;
  logic [3:0] next_ramp_done;
  logic next_fault_latched;
  logic next_reset_oe_n;
  lbrs_rail_t next_rail;
  lbrs_shape_t next_shape;
  logic [3:0] supervised; // Rails under fault watch
  logic fault_now; // Any rail fault this cycle
  logic powered; // Powered-up states
  logic source_on; // Source boost running
  // Timer done flags and ramp levels
  logic reg_dly_done, rst_done, src_dly_done, src_ramp_done;
  logic glow_dly_done, glow_ramp_done, ghigh_ramp_done, shape_dly_done;
  logic [7:0] src_level, glow_level, ghigh_level;

  // Limit a programmed time to its legal span
  function automatic logic [16:0] lbrs_clamp(input logic [16:0] v, input logic [16:0] lo,
                                             input logic [16:0] hi);
    lbrs_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : lbrs_clamp

  // Shared timebase tick [RULE24]
  always_comb begin
    next_tick = 1'b0;
    next_tb_count = tb_count + 16'h0001;
    if (tb_count >= 16'(TICK_CYCLES - 1)) begin
      next_tb_count = 16'h0000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      tb_count <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tb_count <= next_tb_count;
      tick <= next_tick;
    end
  end

  assign powered = (state == LBRS_RST_PULSE) || (state == LBRS_SRC_WAIT) ||
                   (state == LBRS_RAMPING) || (state == LBRS_RUN);
  assign source_on = (state == LBRS_RAMPING) || (state == LBRS_RUN);

  // Sequencing timers
  lbrs_interval_timer u_reg_dly (.mclk(mclk), .srst(srst), .tick(tick),
    .run(state == LBRS_REG_WAIT), .limit(cfg.regulator_start_delay),
    .done(reg_dly_done), .level()); // [RULE2]
  lbrs_interval_timer u_rst (.mclk(mclk), .srst(srst), .tick(tick),
    .run((state == LBRS_RST_PULSE) && logic_rail_up), // [RULE22]
    .limit(lbrs_clamp(cfg.reset_pulse_time, 17'h00000, `LBRS_RST_MAX_US)),
    .done(rst_done), .level());
  lbrs_interval_timer u_src_dly (.mclk(mclk), .srst(srst), .tick(tick),
    .run((state == LBRS_SRC_WAIT) && system_reset_i), // [RULE9]
    .limit(lbrs_clamp(cfg.source_boost_start_delay, 17'h00000, `LBRS_SOURCE_BOOST_START_DELAY_MAX_US)),
    .done(src_dly_done), .level());
  lbrs_interval_timer u_src_ramp (.mclk(mclk), .srst(srst), .tick(tick), .run(source_on),
    .limit(lbrs_clamp(cfg.source_boost_ramp_time, `LBRS_SS2_MIN_US, `LBRS_SS2_MAX_US)),
    .done(src_ramp_done), .level(src_level)); // [RULE10]
  lbrs_interval_timer u_glow_dly (.mclk(mclk), .srst(srst), .tick(tick), .run(source_on),
    .limit(lbrs_clamp(cfg.gate_low_start_delay, 17'h00000, `LBRS_MAX35_US)),
    .done(glow_dly_done), .level()); // [RULE16]
  lbrs_interval_timer u_glow_ramp (.mclk(mclk), .srst(srst), .tick(tick),
    .run(source_on && glow_dly_done),
    .limit(lbrs_clamp(cfg.gate_low_ramp_time, 17'h00000, `LBRS_MAX35_US)),
    .done(glow_ramp_done), .level(glow_level)); // [RULE16]
  lbrs_interval_timer u_ghigh_ramp (.mclk(mclk), .srst(srst), .tick(tick),
    .run(source_on && glow_ramp_done), // [RULE13] [RULE25]
    .limit(lbrs_clamp(cfg.gate_high_ramp_time, `LBRS_SS4_MIN_US, `LBRS_MAX35_US)),
    .done(ghigh_ramp_done), .level(ghigh_level));
  lbrs_interval_timer u_shape_dly (.mclk(mclk), .srst(srst), .tick(tick),
    .run(source_on && ghigh_ramp_done), // [RULE20]
    .limit(lbrs_clamp(cfg.shaping_release_delay, 17'h00000, `LBRS_MAX35_US)),
    .done(shape_dly_done), .level());

  // Rail supervision: 30% trips at once, 70% after the filter [RULE4] [RULE5]
  always_comb begin
    supervised = powered ? ramp_done : 4'h0; // Rails switched off are not watched
    fault_now = 1'b0;
    for (int i = 0; i < `LBRS_NUM_RAILS; i++) begin
      next_uv_count[i] = 17'h00000;
      if (supervised[i] && rail_below_30[i]) begin
        fault_now = 1'b1; // [RULE5]
      end
      if (supervised[i] && rail_below_70[i]) begin
        next_uv_count[i] = uv_count[i];
        if (uv_count[i] > 17'(UV_FILTER_TICKS)) begin
          fault_now = 1'b1; // [RULE4]
        end else if (tick) begin
          next_uv_count[i] = uv_count[i] + 17'h00001;
        end
      end
    end
  end

  // Main sequence
  always_comb begin
    next_state = state;
    next_logic_rail_up = logic_rail_up;
    next_reset_released = reset_released;
    case (state)
      LBRS_OFF: begin
        if (supply_above_lockout) begin
          next_state = LBRS_REG_WAIT; // [RULE2]
        end
      end
      LBRS_REG_WAIT: begin
        if (reg_dly_done) begin
          next_state = LBRS_RST_PULSE;
        end
      end
      LBRS_RST_PULSE: begin
        if (!rail_below_70[`LBRS_RAIL_LOGIC]) begin
          next_logic_rail_up = 1'b1; // No soft start, rail up when in range
        end
        if (rst_done) begin
          next_reset_released = 1'b1; // [RULE23]
          next_state = LBRS_SRC_WAIT;
        end
      end
      LBRS_SRC_WAIT: begin
        if (src_dly_done) begin
          next_state = LBRS_RAMPING; // [RULE9]
        end
      end
      LBRS_RAMPING: begin
        if (shape_dly_done) begin
          next_state = LBRS_RUN; // [RULE20]
        end
      end
      LBRS_RUN: next_state = LBRS_RUN;
      LBRS_DOWN: next_state = LBRS_DOWN; // Left only by power-on reset
      LBRS_FAULT: next_state = LBRS_FAULT; // Latched off [RULE6]
      default: next_state = LBRS_OFF;
    endcase
    // Faults win over lockout, both over the sequence
    if (fault_now && (state != LBRS_FAULT)) begin
      next_state = LBRS_FAULT; // [RULE4] [RULE5] [RULE6]
    end else if (!supply_above_lockout && (state != LBRS_OFF) &&
                 (state != LBRS_FAULT)) begin
      next_state = LBRS_DOWN; // [RULE3] [RULE11] [RULE14] [RULE17]
    end
  end

  // Rail drive, status and reset pin values
  always_comb begin
    next_rail = '0;
    next_rail.logic_supply_level = cfg.logic_supply_level; // [RULE1]
    next_rail.source_boost_frequency_select = cfg.source_boost_frequency_select; // [RULE7]
    next_rail.source_supply_code = cfg.source_supply_code; // [RULE8]
    next_rail.gate_high_code = cfg.gate_high_code; // [RULE12]
    next_rail.gate_low_code = cfg.gate_low_code; // [RULE15]
    next_rail.regulator_en = powered && (next_state != LBRS_DOWN) &&
                             (next_state != LBRS_FAULT); // [RULE2] [RULE3]
    next_rail.source_boost_en = source_on && next_rail.regulator_en; // [RULE11]
    next_rail.gate_low_en = next_rail.source_boost_en && glow_dly_done; // [RULE17]
    next_rail.gate_high_en = next_rail.source_boost_en && glow_ramp_done; // [RULE13] [RULE14]
    next_rail.source_ramp_level = src_level; // [RULE10]
    next_rail.gate_low_ramp_level = glow_level; // [RULE16]
    next_rail.gate_high_ramp_level = ghigh_level; // [RULE13]
    if (next_state == LBRS_DOWN) begin
      next_rail.regulator_discharge = 1'b1; // [RULE3]
      next_rail.source_discharge_switch = 1'b1; // [RULE11]
      next_rail.gate_low_discharge = 1'b1; // [RULE17]
    end
    next_ramp_done = {glow_ramp_done, ghigh_ramp_done, src_ramp_done, logic_rail_up}; // [RULE25]
    next_fault_latched = fault_latched || (next_state == LBRS_FAULT); // [RULE6]
    next_reset_oe_n = next_reset_released; // Pull low until released [RULE22] [RULE23]
  end

  // Gate shaping switches
  always_comb begin
    next_shape_discharging = shape_discharging;
    next_shape = '0;
    if (shaping_control_input || (state != LBRS_RUN)) begin // Falls outside run ignored
      next_shape_discharging = 1'b0;
    end else if (shape_prev) begin
      next_shape_discharging = 1'b1; // Falling edge [RULE19]
    end
    case (next_state)
      LBRS_RUN: begin
        if (shaping_control_input) begin
          next_shape.gate_pass_switch = 1'b1; // [RULE18]
        end else if (next_shape_discharging) begin
          next_shape.first_discharge_switch = 1'b1; // [RULE19]
          next_shape.second_discharge_switch = 1'b1;
        end
      end
      LBRS_DOWN: next_shape.gate_pass_switch = 1'b1; // [RULE21]
      default: next_shape.ground_clamp_switch = 1'b1; // Power-up and fault [RULE20]
    endcase
  end

  // Register all outputs and all state but the timebase
  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= LBRS_OFF;
      logic_rail_up <= 1'b0;
      reset_released <= 1'b0;
      shape_prev <= 1'b0;
      shape_discharging <= 1'b0;
      ramp_done <= 4'h0;
      fault_latched <= 1'b0;
      rail <= '0;
      shape <= '0;
      system_reset_o <= 1'b0;
      system_reset_oe_n <= 1'b0;
      for (int i = 0; i < `LBRS_NUM_RAILS; i++) begin
        uv_count[i] <= 17'h00000;
      end
    end else begin
      state <= next_state;
      logic_rail_up <= next_logic_rail_up;
      reset_released <= next_reset_released;
      shape_prev <= shaping_control_input;
      shape_discharging <= next_shape_discharging;
      ramp_done <= next_ramp_done;
      fault_latched <= next_fault_latched;
      rail <= next_rail;
      shape <= next_shape;
      system_reset_o <= 1'b0;
      system_reset_oe_n <= next_reset_oe_n;
      for (int i = 0; i < `LBRS_NUM_RAILS; i++) begin
        uv_count[i] <= next_uv_count[i];
      end
    end
  end
endmodule : lbrs_sequencer

// File: rtl/lbrs_defines.svh
// Timing counts, field widths and limits for the LCD bias rail sequencer
// Notes on behaviour
// [RULE1] Two-bit logic-supply level setting applied to regulator
// [RULE2] Regulator enabled after lockout clears plus delay
// [RULE3] Regulator off at lockout, discharge asserted
// [RULE4] Rail below 70% over 50 ms disables chip
// [RULE5] Rail below 30% disables chip at once
// [RULE6] Shutdown latched until power-on reset
// [RULE7] Two-bit source boost frequency select
// [RULE8] Source boost target code, 100 mV steps
// [RULE9] Source boost starts delay after reset released
// [RULE10] Source boost ramps over programmed soft-start time
// [RULE11] Source boost off at lockout, rail discharged
// [RULE12] Gate-high boost target setting 18 to 25.5 V
// [RULE13] Gate-high starts after gate-low ramp, ramps linearly
// [RULE14] Gate-high off at lockout, no discharge
// [RULE15] Gate-low pump target, 0.2 V steps
// [RULE16] Gate-low delayed after source ramp start, ramps
// [RULE17] Gate-low off at lockout, discharged to ground
// [RULE18] Control high: pass on, others off
// [RULE19] Control falling edge: pass off, discharges on
// [RULE20] Power-up: clamp on until release delay elapses
// [RULE21] Power-down: pass on, discharges and clamp off
// [RULE22] Reset pulse timed after logic rail ramps
// [RULE23] Released reset output stays high until power-down (code keeps it high through power-down, until power-on reset)
// [RULE24] All timing from one shared timebase
// [RULE25] Ramp-finished flag per rail starts next stage
`ifndef LBRS_DEFINES_SVH
`define LBRS_DEFINES_SVH
`define LBRS_CLK_MHZ 10
`define LBRS_TICK_US 1
`define LBRS_TICK_CYCLES (`LBRS_CLK_MHZ * `LBRS_TICK_US)
`define LBRS_TIME_W 17
`define LBRS_UV_FILTER_MS 50
`define LBRS_UV_FILTER_TICKS (`LBRS_UV_FILTER_MS * 1000 / `LBRS_TICK_US)
`define LBRS_RAIL_LOGIC 0
`define LBRS_RAIL_SOURCE 1
`define LBRS_RAIL_GHIGH 2
`define LBRS_RAIL_GLOW 3
`define LBRS_NUM_RAILS 4
`define LBRS_RST_MAX_US 17'h03A98
`define LBRS_SOURCE_BOOST_START_DELAY_MAX_US 17'h124F8
`define LBRS_SS2_MIN_US 17'h001F4
`define LBRS_SS2_MAX_US 17'h124F8
`define LBRS_SS4_MIN_US 17'h00100
`define LBRS_MAX35_US 17'h088B8
`endif

// File: rtl/lbrs_pkg.sv
// Types shared by the LCD bias rail sequencer
package lbrs_pkg;
  // Sequencer states
  typedef enum logic [2:0] {
    LBRS_OFF = 3'b000,
    LBRS_REG_WAIT = 3'b001,
    LBRS_RST_PULSE = 3'b010,
    LBRS_SRC_WAIT = 3'b011,
    LBRS_RAMPING = 3'b100,
    LBRS_RUN = 3'b101,
    LBRS_DOWN = 3'b110,
    LBRS_FAULT = 3'b111
  } lbrs_state_t;

  // Settings, times in timebase ticks
  typedef struct packed {
    logic [1:0] logic_supply_level;
    logic [1:0] source_boost_frequency_select;
    logic [4:0] source_supply_code;
    logic [3:0] gate_high_code;
    logic [3:0] gate_low_code;
    logic [16:0] regulator_start_delay;
    logic [16:0] reset_pulse_time;
    logic [16:0] source_boost_start_delay;
    logic [16:0] source_boost_ramp_time;
    logic [16:0] gate_low_start_delay;
    logic [16:0] gate_low_ramp_time;
    logic [16:0] gate_high_ramp_time;
    logic [16:0] shaping_release_delay;
  } lbrs_cfg_t;

  // Rail drive towards the analog side
  typedef struct packed {
    logic regulator_en;
    logic regulator_discharge;
    logic source_boost_en;
    logic source_discharge_switch;
    logic gate_high_en;
    logic gate_low_en;
    logic gate_low_discharge;
    logic [1:0] logic_supply_level;
    logic [1:0] source_boost_frequency_select;
    logic [4:0] source_supply_code;
    logic [3:0] gate_high_code;
    logic [3:0] gate_low_code;
    logic [7:0] source_ramp_level;
    logic [7:0] gate_low_ramp_level;
    logic [7:0] gate_high_ramp_level;
  } lbrs_rail_t;

  // Gate shaping switches
  typedef struct packed {
    logic gate_pass_switch;
    logic first_discharge_switch;
    logic second_discharge_switch;
    logic ground_clamp_switch;
  } lbrs_shape_t;
endpackage : lbrs_pkg

// File: dv/lbrs_checker_assertions.sv
// Port checker for the LCD bias rail sequencer
`timescale 1ns/10ps
module lbrs_checker #(
  parameter int TICK_CYCLES = 10,
  parameter int UV_FILTER_TICKS = 50000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Inputs watched
  input wire logic supply_above_lockout,
  input wire logic [3:0] rail_below_30,
  input wire logic shaping_control_input,
  input wire logic system_reset_i,
  // Outputs watched
  input wire logic system_reset_oe_n,
  input lbrs_pkg::lbrs_rail_t rail,
  input lbrs_pkg::lbrs_shape_t shape,
  input wire logic [3:0] ramp_done,
  input wire logic fault_latched
);
  import lbrs_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // Normal running: gate-high ramped and clamp released
  wire logic run_ok = rail.gate_high_en && ramp_done[2] && !shape.ground_clamp_switch;
  // Falling shaping input while running
  sequence s_fall_run;
    $fell(shaping_control_input) && run_ok;
  endsequence
  // Power-down held for two cycles
  sequence s_down;
    rail.regulator_discharge ##1 rail.regulator_discharge;
  endsequence
  short_trip_a: assert property ((|(ramp_done & rail_below_30)) && rail.regulator_en
    |=> fault_latched) else $error("short did not latch a fault");
  fault_hold_a: assert property (fault_latched |=> fault_latched)
    else $error("fault latch released");
  fault_quiet_a: assert property (fault_latched |=> !rail.regulator_en && !rail.source_boost_en
    && !rail.gate_high_en && !rail.gate_low_en && shape == 4'b0001)
    else $error("rails still driven after fault");
  lockout_off_a: assert property ($fell(supply_above_lockout) && rail.regulator_en
    && !fault_latched |=> !rail.regulator_en && rail.regulator_discharge && !rail.gate_high_en
    && rail.source_discharge_switch && rail.gate_low_discharge) else $error("lockout stop wrong");
  down_shape_a: assert property (s_down |-> shape == 4'b1000)
    else $error("shaping switches wrong in power-down");
  reset_hold_a: assert property (system_reset_oe_n && !fault_latched
    |=> system_reset_oe_n || fault_latched) else $error("reset output pulled low again");
  gh_order_a: assert property ($rose(rail.gate_high_en) |-> ramp_done[3] && !ramp_done[2])
    else $error("gate-high started before gate-low ramp");
  src_order_a: assert property ($rose(rail.source_boost_en) |-> system_reset_i && ramp_done[0])
    else $error("source boost started before reset release");
  ramp_top_a: assert property ($rose(ramp_done[2]) |-> rail.gate_high_ramp_level == 8'hFF)
    else $error("ramp done before full level");
  pass_on_a: assert property ($rose(shaping_control_input) && run_ok |=> shape == 4'b1000)
    else $error("pass switch not on");
  shape_fall_a: assert property (s_fall_run |=> shape == 4'b0110)
    else $error("discharge switches not on");
  clamp_up_a: assert property (rail.gate_high_en && !ramp_done[2] |-> shape == 4'b0001)
    else $error("clamp not on during ramp");
  reg_gate_a: assert property ($rose(rail.regulator_en)
    |-> supply_above_lockout && $past(supply_above_lockout, 2)) else $error("regulator too early");
endmodule : lbrs_checker

bind lbrs_sequencer lbrs_checker #(.TICK_CYCLES(TICK_CYCLES), .UV_FILTER_TICKS(UV_FILTER_TICKS))
  u_chk (.mclk(mclk), .srst(srst), .supply_above_lockout(supply_above_lockout),
  .rail_below_30(rail_below_30), .shaping_control_input(shaping_control_input),
  .system_reset_i(system_reset_i), .system_reset_oe_n(system_reset_oe_n), .rail(rail),
  .shape(shape), .ramp_done(ramp_done), .fault_latched(fault_latched));

// File: dv/lbrs_rail_model.sv
// Far-side model: rail comparators and pulled-up reset wire
`timescale 1ns/10ps
module lbrs_rail_model (
  // Drive from the sequencer
  input lbrs_pkg::lbrs_rail_t rail,
  input wire logic system_reset_o,
  input wire logic system_reset_oe_n,
  // Faults the bench asks for
  input wire logic [3:0] short_req,
  input wire logic [3:0] sag_req,
  // Comparators and wire level
  output logic [3:0] rail_below_70,
  output logic [3:0] rail_below_30,
  output logic system_reset_i
);
  import lbrs_pkg::*;
  logic [3:0] en; // Rail enables in comparator order
  assign en = {rail.gate_low_en, rail.gate_high_en, rail.source_boost_en, rail.regulator_en};
  // Unpowered rail reads low; unknown drive counts as unpowered
  assign rail_below_70 = (^en === 1'bx) ? 4'hF : (~en | sag_req | short_req);
  assign rail_below_30 = short_req;
  // Pull-up wins unless the pin sinks
  assign system_reset_i = (system_reset_oe_n === 1'b0) ? system_reset_o : 1'b1;
endmodule : lbrs_rail_model

// File: dv/tb_top.sv
// Self-checking bench for the rail sequencer
`timescale 1ns/10ps
module tb_top;
  import lbrs_pkg::*;
  localparam int TC = 2; // Cycles per tick
  localparam int UV = 50; // Sag filter in ticks
  logic mclk = 1'b0;
  logic srst = 1'b1;
  lbrs_cfg_t cfg = '0;
  logic supply_above_lockout = 1'b0;
  logic shaping_control_input = 1'b0;
  logic [3:0] short_req = 4'h0;
  logic [3:0] sag_req = 4'h0;
  logic [3:0] rail_below_70, rail_below_30, ramp_done;
  logic system_reset_i, system_reset_o, system_reset_oe_n, fault_latched;
  lbrs_rail_t rail;
  lbrs_shape_t shape;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  logic jitter = 1'b0; // Random shaping input while set
  logic [31:0] exp_q[$]; // Expected values, oldest first
  int id_q[$]; // Probe of each expected value
  event note_ev;
  string pname [7] = '{"shape", "enables", "ramp_done", "fault", "reset_pin", "codes",
    "levels"};
  always #50 mclk = ~mclk;
  lbrs_sequencer #(.TICK_CYCLES(TC), .UV_FILTER_TICKS(UV)) dut (.mclk(mclk), .srst(srst),
    .cfg(cfg), .supply_above_lockout(supply_above_lockout), .rail_below_70(rail_below_70),
    .rail_below_30(rail_below_30), .shaping_control_input(shaping_control_input),
    .system_reset_i(system_reset_i), .system_reset_o(system_reset_o),
    .system_reset_oe_n(system_reset_oe_n), .rail(rail), .shape(shape),
    .ramp_done(ramp_done), .fault_latched(fault_latched));
  lbrs_rail_model u_model (.rail(rail), .system_reset_o(system_reset_o),
    .system_reset_oe_n(system_reset_oe_n), .short_req(short_req), .sag_req(sag_req),
    .rail_below_70(rail_below_70), .rail_below_30(rail_below_30),
    .system_reset_i(system_reset_i));
  // Observed value of each probe
  function automatic logic [31:0] obs(input int id);
    case (id)
      0: obs = {28'h0, shape};
      1: obs = {25'h0, rail.regulator_en, rail.regulator_discharge, rail.source_boost_en,
        rail.source_discharge_switch, rail.gate_high_en, rail.gate_low_en, rail.gate_low_discharge};
      2: obs = {28'h0, ramp_done};
      3: obs = {31'h0, fault_latched};
      4: obs = {30'h0, system_reset_o, system_reset_oe_n};
      6: obs = {8'h0, rail.source_ramp_level, rail.gate_low_ramp_level, rail.gate_high_ramp_level};
      default: obs = {15'h0, rail.logic_supply_level, rail.source_boost_frequency_select,
        rail.source_supply_code, rail.gate_high_code, rail.gate_low_code};
    endcase
  endfunction : obs
  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      n_mismatch++;
      $display("unexpected %s: expected %0h, seen %0h", name, want, seen);
    end
  endtask : check
  // Queue an expectation for the monitor
  task automatic note(input int id, input logic [31:0] v);
    id_q.push_back(id);
    exp_q.push_back(v);
    ->note_ev;
  endtask : note
  // Monitor takes every queued note, oldest first, and compares
  always @(note_ev) begin : mon
    int id;
    while (id_q.size() > 0) begin
      id = id_q.pop_front();
      check(pname[id], obs(id), exp_q.pop_front());
    end
  end
  // Advance n edges, then drive just after
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
    if (jitter) shaping_control_input = 1'($urandom);
  endtask : step
  // Wait for mask bits of a probe, bounded
  task automatic wait_for(input int id, input logic [31:0] m, input int lim, output int n);
    n = 0;
    while ((obs(id) & m) !== m && n < lim) begin
      step(1);
      n++;
    end
    if (n >= lim) check("wait", 32'h0, 32'h1);
  endtask : wait_for
  // Interval of d ticks seen as n cycles
  task automatic win(input string nm, input int n, input int d);
    check(nm, 32'(n >= (d - 1) * TC && n <= d * TC + TC + 6), 32'h1);
  endtask : win
  // Reset, then run the whole power-up order
  task automatic power_up(input int k);
    int n;
    int t0;
    supply_above_lockout = 1'b0;
    srst = 1'b1;
    cfg.logic_supply_level = 2'(k);
    cfg.source_boost_frequency_select = 2'(3 - k);
    cfg.source_supply_code = 5'($urandom);
    cfg.gate_high_code = 4'($urandom);
    cfg.gate_low_code = 4'($urandom);
    cfg.regulator_start_delay = 17'($urandom_range(1, 12));
    cfg.reset_pulse_time = 17'($urandom_range(1, 12));
    cfg.source_boost_start_delay = 17'($urandom_range(1, 12));
    cfg.source_boost_ramp_time = 17'($urandom_range(1, 12));
    cfg.gate_low_start_delay = 17'($urandom_range(1, 12));
    cfg.gate_low_ramp_time = 17'($urandom_range(1, 12));
    cfg.gate_high_ramp_time = 17'($urandom_range(1, 12));
    cfg.shaping_release_delay = 17'($urandom_range(1, 12));
    step(5);
    srst = 1'b0;
    jitter = 1'b1;
    step(2);
    note(0, 32'h1);
    supply_above_lockout = 1'b1;
    wait_for(1, 32'h40, 200, n);
    win("reg_delay", n, int'(cfg.regulator_start_delay));
    wait_for(4, 32'h1, 200, n);
    win("reset_pulse", n, int'(cfg.reset_pulse_time));
    wait_for(1, 32'h10, 200, n);
    win("src_delay", n, int'(cfg.source_boost_start_delay));
    t0 = cyc;
    wait_for(1, 32'h04, 400, n);
    note(0, 32'h1);
    note(2, 32'h9);
    jitter = 1'b0;
    wait_for(2, 32'h4, 700, n);
    win("gh_ramp", n, 256);
    shaping_control_input = 1'b0;
    n = 0;
    while (shape.ground_clamp_switch !== 1'b0 && n < 200) begin
      step(1);
      n++;
    end
    win("release", n, int'(cfg.shaping_release_delay));
    note(0, 32'h0);
    note(5, {15'h0, cfg.logic_supply_level, cfg.source_boost_frequency_select,
      cfg.source_supply_code, cfg.gate_high_code, cfg.gate_low_code});
    wait_for(2, 32'hF, 1200, n);
    note(6, 32'h00FFFFFF);
    win("src_ramp", cyc - t0, 500);
  endtask : power_up
  // Verdict
  task automatic results();
    $display("checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  // Cycle ceiling
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin : main
    int n;
    n = $urandom(32'h837BA687);
    for (int k = 0; k < 4; k++) begin
      power_up(k);
      shaping_control_input = 1'b1;
      step(2);
      note(0, 32'h8);
      shaping_control_input = 1'b0;
      step(2);
      note(0, 32'h6);
      n = $urandom_range(0, 3);
      if (k % 3 == 0) begin
        short_req[n] = 1'b1;
        step(2);
        note(3, 32'h1);
        note(1, 32'h0);
        note(0, 32'h1);
        short_req = 4'h0;
        step(100);
        note(1, 32'h0);
        note(3, 32'h1);
      end else if (k % 3 == 1) begin
        sag_req[n] = 1'b1;
        step((UV - 5) * TC);
        note(3, 32'h0);
        wait_for(3, 32'h1, 14 * TC, n);
        note(1, 32'h0);
        sag_req = 4'h0;
      end else begin
        supply_above_lockout = 1'b0;
        step(2);
        note(1, 32'h29);
        note(0, 32'h8);
        note(4, 32'h1);
        shaping_control_input = 1'b1;
        step(2);
        supply_above_lockout = 1'b1;
        step(20);
        note(0, 32'h8);
        note(1, 32'h29);
      end
    end
    step(1);
    results();
  end
endmodule : tb_top
